//--- logic/roc_defs.svh
// Constants for the relay output conditioner: offsets, fields, resets and limits
//
// Summary of operation
// - A rising condition reaches the relay only after the on-delay, 0 to 60000 ms.
// - A falling condition reaches the relay only after the holding time, 0 to 9999 ms.
// - Per relay, positive polarity drives 1 while true and negative polarity drives 0.
// - Relays 2 to 4 keep positive polarity for no-fault, precharge and line sources.
// - Relay 1 holding time is not settable and stays 0 for the no-fault source.
// - Relays 2 to 4 holding time stays 0 for no-fault, precharge and line sources.
// - On-delay stays 0 for no-fault, output, precharge and line contactor sources.
// - Contactor and damper sources exist only on relays 2 to 4, set via the app port.
// - Relays 3 and 4 exist only while their extension card is present.
// - Relay 1 also has an on-delay of 0 to 60000 ms, not settable for the no-fault source.
`ifndef ROC_DEFS_SVH
`define ROC_DEFS_SVH

// Per-relay register block: relay n sits at (n - 1) * stride
`define ROC_RLY_STRIDE  8'h10
`define ROC_SUB_CFG     2'h0
`define ROC_SUB_ON      2'h1
`define ROC_SUB_HOLD    2'h2
`define ROC_OFS_STAT    8'h40
`define ROC_OFS_APP     8'h44

// Field positions
`define ROC_CFG_NEG_BIT 8
`define ROC_APP_SRC_LSB 4

// Limits in milliseconds (60000 and 9999)
`define ROC_ON_MAX_MS   16'hea60
`define ROC_HOLD_MAX_MS 14'h270f

// Reset values
`define ROC_RST_ON      16'h0000
`define ROC_RST_HOLD    14'h0000
`define ROC_RST_NEG     1'b0

// Bus answers
`define ROC_RESP_OKAY   2'h0
`define ROC_RESP_SLVERR 2'h2

`endif

//--- logic/roc_pkg.sv
// Types shared by the relay output conditioner
package roc_pkg;

    // Source selected for a relay
    typedef enum logic [3:0] {
        ROC_SRC_NONE   = 4'h0,
        ROC_SRC_NOFLT  = 4'h1,
        ROC_SRC_LINE   = 4'h2,
        ROC_SRC_OUTC   = 4'h3,
        ROC_SRC_DCPRE  = 4'h4,
        ROC_SRC_DAMPER = 4'h5,
        ROC_SRC_GEN    = 4'h6,
        ROC_SRC_RUN    = 4'h7
    } roc_src_t;

    // Configuration of one relay
    typedef struct packed {
        roc_src_t    src;
        logic        neg;
        logic [15:0] on_ms;
        logic [13:0] hold_ms;
    } roc_cfg_t;

endpackage : roc_pkg

//--- logic/roc_top.sv
// Relay output conditioner with AXI4-Lite configuration
//
// The AXI4-Lite register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "roc_defs.svh"

module roc_top #(
    parameter int AW = 8
) (
    input  wire logic          MCLK,
    input  wire logic          SYS_RST,
    input  wire logic          CLK_EN,
    input  wire logic          MS_TICK,
    input  wire logic [3:0]    COND,
    input  wire logic          CARD3_PRESENT,
    input  wire logic          CARD4_PRESENT,
    output logic      [3:0]    RELAY,
    input  wire logic [AW-1:0] S_AXI_AWADDR,
    input  wire logic          S_AXI_AWVALID,
    output logic               S_AXI_AWREADY,
    input  wire logic [31:0]   S_AXI_WDATA,
    input  wire logic [3:0]    S_AXI_WSTRB,
    input  wire logic          S_AXI_WVALID,
    output logic               S_AXI_WREADY,
    output logic      [1:0]    S_AXI_BRESP,
    output logic               S_AXI_BVALID,
    input  wire logic          S_AXI_BREADY,
    input  wire logic [AW-1:0] S_AXI_ARADDR,
    input  wire logic          S_AXI_ARVALID,
    output logic               S_AXI_ARREADY,
    output logic      [31:0]   S_AXI_RDATA,
    output logic      [1:0]    S_AXI_RRESP,
    output logic               S_AXI_RVALID,
    input  wire logic          S_AXI_RREADY
);

    localparam int NR = 4;

    // ************************************************************
    // Helper functions
    // ************************************************************

    // Sources reachable only through the application port
    function automatic logic app_only(input logic [3:0] s);
        app_only = (s >= 4'h2) && (s <= 4'h5);
    endfunction : app_only

    // Sources that pin the on-delay to zero
    function automatic logic on_lock(input logic [3:0] s);
        on_lock = (s >= 4'h1) && (s <= 4'h4);
    endfunction : on_lock

    // Sources that pin holding time to zero and polarity to positive
    function automatic logic hold_lock(input logic [1:0] i, input logic [3:0] s);
        if (i == 2'h0) begin
            hold_lock = (s == roc_pkg::ROC_SRC_NOFLT);
        end else begin
            hold_lock = (s == roc_pkg::ROC_SRC_NOFLT) || (s == roc_pkg::ROC_SRC_DCPRE)
                        || (s == roc_pkg::ROC_SRC_LINE);
        end
    endfunction : hold_lock

    // Selecting a source clears whatever it locks
    function automatic roc_pkg::roc_cfg_t set_src(input roc_pkg::roc_cfg_t c,
                                                  input logic [1:0] i,
                                                  input logic [3:0] s);
        set_src = c;
        set_src.src = roc_pkg::roc_src_t'(s);
        if (on_lock(s)) begin
            set_src.on_ms = `ROC_RST_ON;
        end
        if (hold_lock(i, s)) begin
            set_src.hold_ms = `ROC_RST_HOLD;
            set_src.neg = `ROC_RST_NEG;
        end
    endfunction : set_src

    // Configuration after reset
    function automatic roc_pkg::roc_cfg_t dflt(input logic [1:0] i);
        dflt.src = (i == 2'h1) ? roc_pkg::ROC_SRC_RUN : roc_pkg::ROC_SRC_NONE;
        dflt.neg = `ROC_RST_NEG;
        dflt.on_ms = `ROC_RST_ON;
        dflt.hold_ms = `ROC_RST_HOLD;
    endfunction : dflt

    // Register word of one relay
    function automatic logic [31:0] rly_word(input roc_pkg::roc_cfg_t c, input logic [1:0] sub);
        case (sub)
            `ROC_SUB_CFG: rly_word = {23'h0, c.neg, 4'h0, c.src};
            `ROC_SUB_ON: rly_word = {16'h0, c.on_ms};
            `ROC_SUB_HOLD: rly_word = {18'h0, c.hold_ms};
            default: rly_word = 32'h0;
        endcase
    endfunction : rly_word

    // Byte-lane merge of a write into an old word
    function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] d,
                                           input logic [3:0] st);
        for (int b = 0; b < 4; b++) begin
            wmerge[8*b +: 8] = st[b] ? d[8*b +: 8] : o[8*b +: 8];
        end
    endfunction : wmerge

    // ************************************************************
    // Declarations
    // ************************************************************

    roc_pkg::roc_cfg_t cfg_reg [NR];
    roc_pkg::roc_cfg_t cfg_next [NR];
    logic [NR-1:0]     state_reg;
    logic [15:0]       cnt_reg [NR];
    logic [15:0]       tgt [NR];
    logic [NR-1:0]     present;
    logic [NR-1:0]     cond_eff;
    logic [NR-1:0]     relay_reg;
    logic              awready_reg;
    logic              wready_reg;
    logic              bvalid_reg;
    logic [1:0]        bresp_reg;
    logic              aw_ok_reg;
    logic              w_ok_reg;
    logic [AW-1:0]     awaddr_reg;
    logic [31:0]       wdata_reg;
    logic [3:0]        wstrb_reg;
    logic              arready_reg;
    logic              rvalid_reg;
    logic [31:0]       rdata_reg;
    logic [1:0]        rresp_reg;
    logic              do_wr;

    // Address is a live register word
    function automatic logic addr_ok(input logic [AW-1:0] a, input logic [NR-1:0] p);
        if ((a == `ROC_OFS_STAT) || (a == `ROC_OFS_APP)) begin
            addr_ok = 1'b1;
        end else begin
            addr_ok = (a[7:6] == 2'h0) && (a[3:2] != 2'h3) && (a[1:0] == 2'h0) && p[a[5:4]];
        end
    endfunction : addr_ok

    // ************************************************************
    // Relay presence and conditions
    // ************************************************************

    // Extension relays follow their cards
    assign present = {CARD4_PRESENT, CARD3_PRESENT, 2'b11};

    // Condition counts only for a live relay with a source; target per direction
    always_comb begin
        for (int i = 0; i < NR; i++) begin
            cond_eff[i] = COND[i] && present[i] && (cfg_reg[i].src != roc_pkg::ROC_SRC_NONE);
            tgt[i] = cond_eff[i] ? cfg_reg[i].on_ms : {2'b00, cfg_reg[i].hold_ms};
        end
    end

    // ************************************************************
    // Delay and hold timing
    // ************************************************************

    // Count ms ticks while the condition differs from the relay state
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            for (int i = 0; i < NR; i++) begin
                state_reg[i] <= 1'b0;
                cnt_reg[i] <= 16'h0000;
            end
        end else if (CLK_EN) begin
            for (int i = 0; i < NR; i++) begin
                if (cond_eff[i] == state_reg[i]) begin
                    cnt_reg[i] <= 16'h0000;
                end else if (tgt[i] == 16'h0000) begin
                    state_reg[i] <= cond_eff[i];
                    cnt_reg[i] <= 16'h0000;
                end else if (MS_TICK) begin
                    if (cnt_reg[i] == tgt[i] - 16'h0001) begin
                        state_reg[i] <= cond_eff[i];
                        cnt_reg[i] <= 16'h0000;
                    end else begin
                        cnt_reg[i] <= cnt_reg[i] + 16'h0001;
                    end
                end
            end
        end
    end

    // Polarity applied at the output flop; an absent relay is held off at the next enabled clock
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            relay_reg <= 4'h0;
        end else if (CLK_EN) begin
            for (int i = 0; i < NR; i++) begin
                relay_reg[i] <= present[i] && (state_reg[i] ^ cfg_reg[i].neg);
            end
        end
    end

    assign RELAY = relay_reg;

    // ************************************************************
    // Configuration registers
    // ************************************************************

    assign do_wr = aw_ok_reg && w_ok_reg && !bvalid_reg;

    // Next configuration: absent relays return to defaults, writes filtered by locks
    always_comb begin
        logic [1:0]  ri;
        logic [31:0] m;
        ri = awaddr_reg[5:4];
        m = 32'h0;
        for (int i = 0; i < NR; i++) begin
            cfg_next[i] = present[i] ? cfg_reg[i] : dflt(2'(i));
        end
        if (do_wr && addr_ok(awaddr_reg, present)) begin
            if (awaddr_reg == `ROC_OFS_APP) begin
                ri = wdata_reg[1:0];
                m[3:0] = wdata_reg[`ROC_APP_SRC_LSB +: 4];
                if ((ri != 2'h0) && present[ri] && app_only(m[3:0]) && wstrb_reg[0]) begin
                    cfg_next[ri] = set_src(cfg_reg[ri], ri, m[3:0]);
                end
            end else if (awaddr_reg != `ROC_OFS_STAT) begin
                m = wmerge(rly_word(cfg_reg[ri], awaddr_reg[3:2]), wdata_reg, wstrb_reg);
                case (awaddr_reg[3:2])
                    `ROC_SUB_CFG: begin
                        if (!app_only(m[3:0])) begin
                            cfg_next[ri] = set_src(cfg_reg[ri], ri, m[3:0]);
                        end
                        if (!hold_lock(ri, cfg_next[ri].src)) begin
                            cfg_next[ri].neg = m[`ROC_CFG_NEG_BIT];
                        end
                    end
                    `ROC_SUB_ON: begin
                        if (!on_lock(cfg_reg[ri].src)) begin
                            cfg_next[ri].on_ms = (m[15:0] > `ROC_ON_MAX_MS) ? `ROC_ON_MAX_MS
                                                 : m[15:0];
                        end
                    end
                    `ROC_SUB_HOLD: begin
                        if (!hold_lock(ri, cfg_reg[ri].src)) begin
                            cfg_next[ri].hold_ms = (m[15:0] > 16'(`ROC_HOLD_MAX_MS))
                                ? `ROC_HOLD_MAX_MS : m[13:0];
                        end
                    end
                    default: begin
                        cfg_next[ri] = cfg_next[ri];
                    end
                endcase
            end
        end
    end

    // Configuration store
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            for (int i = 0; i < NR; i++) begin
                cfg_reg[i] <= dflt(2'(i));
            end
        end else if (CLK_EN) begin
            for (int i = 0; i < NR; i++) begin
                cfg_reg[i] <= cfg_next[i];
            end
        end
    end

    // ************************************************************
    // AXI4-Lite write channel
    // ************************************************************

    // Address and data taken in either order, response after both
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            awready_reg <= 1'b1;
            wready_reg <= 1'b1;
            aw_ok_reg <= 1'b0;
            w_ok_reg <= 1'b0;
            awaddr_reg <= '0;
            wdata_reg <= 32'h0;
            wstrb_reg <= 4'h0;
            bvalid_reg <= 1'b0;
            bresp_reg <= `ROC_RESP_OKAY;
        end else if (CLK_EN) begin
            if (S_AXI_AWVALID && awready_reg) begin
                awaddr_reg <= S_AXI_AWADDR;
                aw_ok_reg <= 1'b1;
                awready_reg <= 1'b0;
            end
            if (S_AXI_WVALID && wready_reg) begin
                wdata_reg <= S_AXI_WDATA;
                wstrb_reg <= S_AXI_WSTRB;
                w_ok_reg <= 1'b1;
                wready_reg <= 1'b0;
            end
            if (do_wr) begin
                bvalid_reg <= 1'b1;
                bresp_reg <= addr_ok(awaddr_reg, present) ? `ROC_RESP_OKAY : `ROC_RESP_SLVERR;
            end
            if (bvalid_reg && S_AXI_BREADY) begin
                bvalid_reg <= 1'b0;
                aw_ok_reg <= 1'b0;
                w_ok_reg <= 1'b0;
                awready_reg <= 1'b1;
                wready_reg <= 1'b1;
            end
        end
    end

    assign S_AXI_AWREADY = awready_reg;
    assign S_AXI_WREADY = wready_reg;
    assign S_AXI_BVALID = bvalid_reg;
    assign S_AXI_BRESP = bresp_reg;

    // ************************************************************
    // AXI4-Lite read channel
    // ************************************************************

    // One read at a time, data one cycle after the address
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            arready_reg <= 1'b1;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0;
            rresp_reg <= `ROC_RESP_OKAY;
        end else if (CLK_EN) begin
            if (S_AXI_ARVALID && arready_reg) begin
                arready_reg <= 1'b0;
                rvalid_reg <= 1'b1;
                rresp_reg <= addr_ok(S_AXI_ARADDR, present) ? `ROC_RESP_OKAY
                             : `ROC_RESP_SLVERR;
                if (S_AXI_ARADDR == `ROC_OFS_STAT) begin
                    rdata_reg <= {20'h0, present, relay_reg, state_reg}; // Live status
                end else if (addr_ok(S_AXI_ARADDR, present)
                             && (S_AXI_ARADDR != `ROC_OFS_APP)) begin
                    rdata_reg <= rly_word(cfg_reg[S_AXI_ARADDR[5:4]], S_AXI_ARADDR[3:2]);
                end else begin
                    rdata_reg <= 32'h0;
                end
            end else if (rvalid_reg && S_AXI_RREADY) begin
                rvalid_reg <= 1'b0;
                arready_reg <= 1'b1;
            end
        end
    end

    assign S_AXI_ARREADY = arready_reg;
    assign S_AXI_RVALID = rvalid_reg;
    assign S_AXI_RDATA = rdata_reg;
    assign S_AXI_RRESP = rresp_reg;

    // ************************************************************
    // Checks
    // ************************************************************

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (SYS_RST);

    for (genvar g = 0; g < NR; g++) begin : g_chk
        early_rise_a: assert property (CLK_EN && !state_reg[g] && cond_eff[g]
            && (tgt[g] != 16'h0) && !(MS_TICK && (cnt_reg[g] == tgt[g] - 16'h1))
            |=> !state_reg[g]) else $error("relay rose before on-delay");
        early_fall_a: assert property (CLK_EN && state_reg[g] && !cond_eff[g]
            && (tgt[g] != 16'h0) && !(MS_TICK && (cnt_reg[g] == tgt[g] - 16'h1))
            |=> state_reg[g]) else $error("relay fell before holding time");
        pol_out_a: assert property (CLK_EN |=>
            RELAY[g] == ($past(present[g]) && ($past(state_reg[g]) ^ $past(cfg_reg[g].neg))))
            else $error("relay output polarity wrong");
        pol_lock_a: assert property (hold_lock(2'(g), cfg_reg[g].src)
            |-> !cfg_reg[g].neg) else $error("locked polarity not positive");
        hold_zero_a: assert property (CLK_EN && state_reg[g] && !cond_eff[g]
            && hold_lock(2'(g), cfg_reg[g].src) |=> !state_reg[g])
            else $error("locked holding time not zero");
        hold_reg_a: assert property (hold_lock(2'(g), cfg_reg[g].src)
            |-> (cfg_reg[g].hold_ms == 14'h0)) else $error("locked hold register not zero");
        on_zero_a: assert property (CLK_EN && !state_reg[g] && cond_eff[g]
            && on_lock(cfg_reg[g].src) |=> state_reg[g]) else $error("locked on-delay not zero");
        restart_a: assert property (CLK_EN && (cond_eff[g] == state_reg[g])
            |=> (cnt_reg[g] == 16'h0)) else $error("counter did not restart");
        on_max_a: assert property (cfg_reg[g].on_ms <= `ROC_ON_MAX_MS)
            else $error("on-delay above limit");
    end

    src_first_a: assert property (!app_only(cfg_reg[0].src))
        else $error("relay 1 holds an extension-only source");
    absent_off_a: assert property (!present[3] && $past(!present[3]) && CLK_EN
        |=> !RELAY[3]) else $error("absent relay driven");

endmodule : roc_top

//--- sim/roc_contacts.sv
// Relay contact model at the far side of the conditioner
`timescale 1ns/1ps
module roc_contacts (
    input  wire logic       MCLK,
    input  wire logic [3:0] RELAY,
    output logic      [3:0] closed
);
    // Contacts pick up one clock after the coil drive changes
    always_ff @(posedge MCLK) begin
        closed <= RELAY;
    end
endmodule : roc_contacts

//--- sim/tb_top.sv
// Self-checking bench for the relay output conditioner
`timescale 1ns/1ps
module tb_top;
    logic        clk, rst, clk_en, tick, card3, card4, awv, wv, bry, arv, rry, awr, wr, bv, arr, rv;
    logic [3:0]  cond, relay, wstrb, m_rly;
    logic [7:0]  awa, ara;
    logic [31:0] wd, rd, got;
    logic [1:0]  bresp, rresp, rsp;
    int          err_total, cmp_count, seed, cyc;
    bit          chk;
    int          m_src[4], m_neg[4], m_on[4], m_hold[4], m_st[4], m_cnt[4];
    int          on_t[4] = '{3, 0, 5, 1};
    int          hold_t[4] = '{2, 4, 0, 1};

    roc_top i_roc_top (.MCLK(clk), .SYS_RST(rst), .CLK_EN(clk_en), .MS_TICK(tick), .COND(cond),
        .CARD3_PRESENT(card3), .CARD4_PRESENT(card4), .RELAY(relay), .S_AXI_AWADDR(awa),
        .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(wstrb),
        .S_AXI_WVALID(wv), .S_AXI_WREADY(wr), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv),
        .S_AXI_BREADY(bry), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
        .S_AXI_RDATA(rd), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rry));
    roc_contacts i_roc_contacts (.MCLK(clk), .RELAY(relay), .closed());

    // ************************************************************
    // Reference model and checks
    // ************************************************************
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            err_total++;
            $display("ERROR %0t got %h exp %h", $time, g, e);
        end
    endtask : cmp

    task automatic give_verdict();
        if (err_total == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : give_verdict

    function automatic bit lk_on(int s);
        return s >= 1 && s <= 4;
    endfunction : lk_on

    function automatic bit lk_h(int i, int s);
        return s == 1 || (i > 0 && (s == 2 || s == 4));
    endfunction : lk_h

    function automatic bit pres(int i);
        return i < 2 || (i == 2 ? card3 : card4);
    endfunction : pres

    // Locking sources clear the stored values they pin
    task automatic m_lock(int i);
        if (lk_on(m_src[i])) m_on[i] = 0;
        if (lk_h(i, m_src[i])) begin
            m_hold[i] = 0;
            m_neg[i] = 0;
        end
    endtask : m_lock

    // Expected answer and side effect of one register access
    task automatic m_acc(input bit w, input logic [7:0] a, input logic [31:0] d,
                         output logic [31:0] q, output logic [1:0] r);
        int i, s, x;
        i = a[5:4];
        q = 32'h0;
        r = 2'h0;
        if (a == 8'h44) begin
            x = d[1:0];
            s = d[7:4];
            if (w && x > 0 && pres(x) && s >= 2 && s <= 5) begin
                m_src[x] = s;
                m_lock(x);
            end
        end else if (a == 8'h40) begin
            q = {20'h0, pres(3), pres(2), 2'b11, m_rly,
                 m_st[3][0], m_st[2][0], m_st[1][0], m_st[0][0]};
        end else if (a > 8'h3f || a[3:2] == 2'h3 || !pres(i)) begin
            r = 2'h2;
        end else if (a[3:2] == 2'h0) begin
            if (w) begin
                s = d[3:0];
                if (s < 2 || s > 5) m_src[i] = s;
                m_lock(i);
                if (!lk_h(i, m_src[i])) m_neg[i] = d[8];
            end
            q = (m_neg[i] << 8) | m_src[i];
        end else if (a[3:2] == 2'h1) begin
            if (w && !lk_on(m_src[i])) m_on[i] = d[15:0] > 16'hea60 ? 16'hea60 : d[15:0];
            q = m_on[i];
        end else begin
            if (w && !lk_h(i, m_src[i])) m_hold[i] = d[15:0] > 16'h270f ? 16'h270f : d[15:0];
            q = m_hold[i];
        end
    endtask : m_acc

    // Relay path: delay counters on the ms tick, output is state xor polarity
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 4; i++) begin
                m_src[i] = (i == 1) ? 7 : 0;
                {m_neg[i], m_on[i], m_hold[i], m_st[i], m_cnt[i]} = '0;
            end
            m_rly = 4'h0;
        end else if (clk_en) begin
            for (int i = 0; i < 4; i++) begin
                int e, d;
                if (!pres(i)) {m_src[i], m_neg[i], m_on[i], m_hold[i]} = '0;
                m_rly[i] = pres(i) ? m_st[i][0] ^ m_neg[i][0] : 1'b0;
                e = cond[i] && m_src[i] != 0;
                d = e ? m_on[i] : m_hold[i];
                if (e == m_st[i]) m_cnt[i] = 0;
                else if (d == 0) m_st[i] = e;
                else if (tick) begin
                    m_cnt[i]++;
                    if (m_cnt[i] >= d) begin
                        m_st[i] = e;
                        m_cnt[i] = 0;
                    end
                end
            end
        end
    end

    // Relay outputs checked each cycle once settled
    always @(negedge clk) begin
        if (chk && !rst) cmp({28'h0, relay}, {28'h0, m_rly});
    end

    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            err_total++;
            give_verdict();
        end
    end

    // ************************************************************
    // Bus master tasks
    // ************************************************************
    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] mq;
        logic [1:0]  me;
        chk = 0;
        @(posedge clk);
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bry <= 1'b1;
        forever begin
            @(posedge clk);
            if (awr) awv <= 1'b0;
            if (wr) wv <= 1'b0;
            if (bv) begin
                bry <= 1'b0;
                rsp = bresp;
                break;
            end
        end
        m_acc(1'b1, a, d, mq, me);
        cmp({30'h0, rsp}, {30'h0, me});
        repeat (2) @(posedge clk);
        chk = 1;
    endtask : bus_wr

    task automatic bus_rd(input logic [7:0] a);
        logic [31:0] mq;
        logic [1:0]  me;
        @(posedge clk);
        ara <= a;
        arv <= 1'b1;
        rry <= 1'b1;
        forever begin
            @(posedge clk);
            if (arr) arv <= 1'b0;
            if (rv) begin
                rry <= 1'b0;
                got = rd;
                rsp = rresp;
                break;
            end
        end
        m_acc(1'b0, a, 32'h0, mq, me);
        cmp(got, mq);
        cmp({30'h0, rsp}, {30'h0, me});
    endtask : bus_rd

    // Clock at 200 MHz
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        {clk_en, card3, card4, rst} = 4'hf;
        {tick, awv, wv, bry, arv, rry, chk} = '0;
        {cond, awa, ara, wd} = '0;
        wstrb = 4'hf;
        seed = 26;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk = 1;
        for (int i = 0; i < 12; i++) bus_rd(8'(i * 4));
        bus_rd(8'h4c);
        bus_wr(8'h3c, 32'h1);
        bus_wr(8'h04, 32'hffff);
        bus_wr(8'h08, 32'hffff);
        bus_rd(8'h04);
        bus_rd(8'h08);
        for (int i = 0; i < 4; i++) begin
            bus_wr(8'(i * 16), ((i & 1) << 8) | (6 + i));
            bus_wr(8'(i * 16 + 4), on_t[i]);
            bus_wr(8'(i * 16 + 8), hold_t[i]);
        end
        repeat (4000) begin
            @(posedge clk);
            if (($random(seed) & 15) == 0) cond <= 4'($random(seed));
            tick <= ($random(seed) & 3) == 0;
            clk_en <= ($random(seed) & 7) != 0;
        end
        @(posedge clk);
        cond <= 4'h0;
        clk_en <= 1'b1;
        repeat (12) begin
            @(posedge clk);
            tick <= 1'b1;
            @(posedge clk);
            tick <= 1'b0;
        end
        bus_wr(8'h00, 32'h1);
        bus_wr(8'h04, 32'h40);
        bus_wr(8'h08, 32'h40);
        bus_wr(8'h00, 32'h101);
        for (int k = 0; k < 3; k++) bus_rd(8'(k * 4));
        for (int s = 2; s < 6; s++) begin
            int x;
            x = 1 + (s % 3);
            bus_wr(8'(x * 16 + 4), 32'h64);
            bus_wr(8'(x * 16 + 8), 32'h64);
            bus_wr(8'h44, (s << 4) | x);
            bus_wr(8'(x * 16), 32'h102);
            bus_wr(8'(x * 16 + 4), 32'h7);
            bus_wr(8'(x * 16 + 8), 32'h7);
            for (int k = 0; k < 3; k++) bus_rd(8'(x * 16 + k * 4));
        end
        for (int k = 0; k < 32; k++) begin
            @(posedge clk);
            cond <= (k < 16) ? 4'hf : 4'h0;
            tick <= k[0];
        end
        @(posedge clk);
        tick <= 1'b0;
        bus_wr(8'h44, 32'h20);
        bus_rd(8'h00);
        {card3, card4} <= 2'b00;
        repeat (2) @(posedge clk);
        bus_rd(8'h20);
        bus_rd(8'h30);
        bus_wr(8'h44, 32'h22);
        {card3, card4} <= 2'b11;
        repeat (2) @(posedge clk);
        bus_rd(8'h20);
        bus_rd(8'h40);
        give_verdict();
    end
endmodule : tb_top
